// File: src/dpis_dev.sv
`timescale 1ns/1ps
`default_nettype none
// device-side power-up sequencer, mode registers and burst tracking
module dpis_dev #(
    parameter int INIT_CYC = dpis_pkg::INIT_CYC_DEF
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // pins from the controller
    input  wire logic                       reset_pin_n,
    input  wire logic                       ck_pin,
    input  wire logic                       cke_pin,
    input  wire logic                       odt_pin,
    input  wire dpis_pkg::dpis_cmd_t        cmd_pin,
    // status
    output dpis_pkg::dpis_state_t           state,
    output logic                            internal_ready,
    output logic                            init_done,
    output logic                            odt_term_en,
    output dpis_pkg::dpis_cfg_t             cfg,
    // access tracking
    output logic                            row_open,
    output logic                            open_bg,
    output logic [1:0]                      open_ba,
    output logic [dpis_pkg::ROW_W-1:0]      open_row,
    output logic                            burst_active,
    output logic                            burst_chop,
    output logic                            auto_pre,
    output logic                            beat_strobe
);
    localparam int CW = $clog2(INIT_CYC + 1);
    localparam int SW = 4 + $bits(dpis_pkg::dpis_cmd_t);
    localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYC - 1);

    // elaboration check, the counter needs a last value apart from zero
    if (INIT_CYC < 2) begin : g_bad_init
        $error("dpis_dev: INIT_CYC must be at least two");
    end

    // synchronised pins
    logic                rst_s;
    logic                ck_s;
    logic                cke_s;
    logic                odt_s;
    dpis_pkg::dpis_cmd_t cmd_s;

    dpis_sync #(.W(SW)) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .pin_i  ({reset_pin_n, ck_pin, cke_pin, odt_pin, cmd_pin}),
        .sync_o ({rst_s, ck_s, cke_s, odt_s, cmd_s})
    );

    // registered state
    dpis_pkg::dpis_state_t       st_q, st_d;
    logic [CW-1:0]               cnt_q, cnt_d;
    logic                        ck_q, ck_d;
    logic                        odt_q, odt_d;
    logic                        done_q, done_d;
    logic [dpis_pkg::MR_W-1:0]   mr_q [dpis_pkg::MR_NUM];
    logic [dpis_pkg::MR_W-1:0]   mr_d [dpis_pkg::MR_NUM];
    logic                        open_q, open_d;
    logic                        bg_q, bg_d;
    logic [1:0]                  ba_q, ba_d;
    logic [dpis_pkg::ROW_W-1:0]  row_q, row_d;
    logic [3:0]                  beats_q, beats_d;
    logic                        chop_q, chop_d;
    logic                        ap_q, ap_d;

    // decoded command on a rising clock edge
    logic       ck_rise;
    logic       ck_edge;
    logic       cmd_live;
    logic       is_mrs;
    logic       is_act;
    logic       is_col;
    logic       is_zql;
    logic [2:0] mr_sel;
    logic       col_chop;

    // burst chop from the length field and A12
    function automatic logic chop_of(input logic [1:0] bl, input logic a12);
        case (bl)
            dpis_pkg::BL_FIX4: chop_of = 1'b1;
            dpis_pkg::BL_OTF:  chop_of = ~a12;
            default:           chop_of = 1'b0;
        endcase
    endfunction

    // command decode, only while clock enable is high in the running state
    always_comb begin
        ck_rise  = ck_s & ~ck_q;
        ck_edge  = ck_s ^ ck_q;
        cmd_live = ck_rise && cke_s && st_q == dpis_pkg::ST_RUN && !cmd_s.cs_n;
        is_act   = cmd_live && !cmd_s.act_n;
        is_mrs   = cmd_live && cmd_s.act_n && cmd_s.op == dpis_pkg::OP_MRS;
        is_col   = cmd_live && cmd_s.act_n && open_q
                   && (cmd_s.op == dpis_pkg::OP_RD || cmd_s.op == dpis_pkg::OP_WR);
        is_zql   = cmd_live && cmd_s.act_n && cmd_s.op == dpis_pkg::OP_ZQ && cmd_s.addr[dpis_pkg::A_ZQL];
        mr_sel   = {cmd_s.bg0, cmd_s.ba};
        col_chop = chop_of(dpis_pkg::BL_FIX8 | mr_q[dpis_pkg::MR0][1:0], cmd_s.addr[dpis_pkg::A_BC]);
    end

    // sequencer, mode registers and access tracking
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        ck_d    = ck_s;
        odt_d   = odt_q;
        done_d  = done_q;
        mr_d    = mr_q;
        open_d  = open_q;
        bg_d    = bg_q;
        ba_d    = ba_q;
        row_d   = row_q;
        beats_d = beats_q;
        chop_d  = chop_q;
        ap_d    = ap_q;
        case (st_q)
            dpis_pkg::ST_RESET: begin
                cnt_d = '0;
                if (rst_s) st_d = dpis_pkg::ST_INIT;
            end
            dpis_pkg::ST_INIT: begin
                // internal setup counts on the core clock only
                if (cnt_q == INIT_LAST) st_d = dpis_pkg::ST_WCKE;
                else cnt_d = cnt_q + CW'(1);
            end
            dpis_pkg::ST_WCKE: begin
                if (ck_rise && cke_s) st_d = dpis_pkg::ST_RUN;
            end
            dpis_pkg::ST_RUN: begin
                st_d = dpis_pkg::ST_RUN;
            end
            default: st_d = dpis_pkg::ST_RESET;
        endcase
        // termination off until clock enable is registered high
        odt_d = (st_d == dpis_pkg::ST_RUN) && odt_s;
        // mode register write; the controller must program all of them
        if (is_mrs && mr_sel < 3'(dpis_pkg::MR_NUM)) begin
            mr_d[mr_sel] = cmd_s.addr[dpis_pkg::MR_W-1:0];
        end
        // long calibration marks the end of the init sequence
        if (is_zql) done_d = 1'b1;
        // activate latches group, bank and row
        if (is_act) begin
            open_d = 1'b1;
            bg_d   = cmd_s.bg0;
            ba_d   = cmd_s.ba;
            row_d  = cmd_s.addr[dpis_pkg::ROW_W-1:0];
        end
        // one beat per clock edge, two per period
        if (ck_edge && beats_q != 4'h0) beats_d = beats_q - 4'h1;
        // column command starts a burst of eight or four
        if (is_col) begin
            chop_d  = col_chop;
            beats_d = col_chop ? dpis_pkg::BEATS_BC4 : dpis_pkg::BEATS_BL8;
            ap_d    = cmd_s.addr[dpis_pkg::A_AP];
            if (cmd_s.addr[dpis_pkg::A_AP]) open_d = 1'b0;
        end
        // reset pin low returns to defaults
        if (!rst_s) begin
            st_d    = dpis_pkg::ST_RESET;
            cnt_d   = '0;
            odt_d   = 1'b0;
            done_d  = 1'b0;
            open_d  = 1'b0;
            beats_d = 4'h0;
            for (int i = 0; i < dpis_pkg::MR_NUM; i++) mr_d[i] = dpis_pkg::MR_RST;
        end
    end

    // register everything
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q    <= dpis_pkg::ST_RESET;
            cnt_q   <= '0;
            ck_q    <= 1'b0;
            odt_q   <= 1'b0;
            done_q  <= 1'b0;
            for (int i = 0; i < dpis_pkg::MR_NUM; i++) mr_q[i] <= dpis_pkg::MR_RST;
            open_q  <= 1'b0;
            bg_q    <= 1'b0;
            ba_q    <= 2'h0;
            row_q   <= '0;
            beats_q <= 4'h0;
            chop_q  <= 1'b0;
            ap_q    <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            ck_q    <= ck_d;
            odt_q   <= odt_d;
            done_q  <= done_d;
            mr_q    <= mr_d;
            open_q  <= open_d;
            bg_q    <= bg_d;
            ba_q    <= ba_d;
            row_q   <= row_d;
            beats_q <= beats_d;
            chop_q  <= chop_d;
            ap_q    <= ap_d;
        end
    end

    // outputs
    assign state          = st_q;
    assign internal_ready = st_q == dpis_pkg::ST_WCKE || st_q == dpis_pkg::ST_RUN;
    assign init_done      = done_q;
    assign odt_term_en    = odt_q;
    assign row_open       = open_q;
    assign open_bg        = bg_q;
    assign open_ba        = ba_q;
    assign open_row       = row_q;
    assign burst_active   = beats_q != 4'h0;
    assign burst_chop     = chop_q;
    assign auto_pre       = ap_q;
    assign beat_strobe    = ck_edge && beats_q != 4'h0;

    // configuration fields from the mode registers
    assign cfg.gear_quarter = mr_q[dpis_pkg::MR3][dpis_pkg::MR3_GDM];
    assign cfg.pda_en       = mr_q[dpis_pkg::MR3][dpis_pkg::MR3_PDA];
    assign cfg.mps_en       = mr_q[dpis_pkg::MR4][dpis_pkg::MR4_MPS];
    assign cfg.cs_lat       = mr_q[dpis_pkg::MR4][dpis_pkg::MR4_CALL +: 3];
    assign cfg.par_lat      = mr_q[dpis_pkg::MR5][dpis_pkg::MR5_PLL +: 3];
    assign cfg.hppr_en      = mr_q[dpis_pkg::MR4][dpis_pkg::MR4_HPPR];
    assign cfg.sppr_en      = mr_q[dpis_pkg::MR4][dpis_pkg::MR4_SPPR];

    // checks
    odt_hiz_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q != dpis_pkg::ST_RUN) |-> !odt_term_en)
        else $error("termination enabled before clock enable registered");
    reset_default_a: assert property (@(posedge clk) disable iff (!arst_n)
        !rst_s |=> (cfg == '0 && st_q == dpis_pkg::ST_RESET && !init_done))
        else $error("defaults not restored by reset pin");
    init_count_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q == dpis_pkg::ST_INIT && rst_s && cnt_q != INIT_LAST) |=> cnt_q == $past(cnt_q) + CW'(1))
        else $error("internal init counter stalled");
    init_end_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q == dpis_pkg::ST_INIT && rst_s && cnt_q == INIT_LAST) |=> st_q == dpis_pkg::ST_WCKE)
        else $error("internal init did not finish on time");
    cke_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_q == dpis_pkg::ST_WCKE && rst_s && ck_rise && cke_s) |=> (st_q == dpis_pkg::ST_RUN) ##1 (odt_q == $past(odt_s)))
        else $error("clock enable not registered");
    burst_len_a: assert property (@(posedge clk) disable iff (!arst_n)
        (is_col && rst_s) |=> beats_q == ($past(col_chop) ? dpis_pkg::BEATS_BC4 : dpis_pkg::BEATS_BL8))
        else $error("wrong burst length");
    beat_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        (beat_strobe && !is_col && rst_s) |=> beats_q == $past(beats_q) - 4'h1)
        else $error("beat count not stepping per clock edge");
    bank_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
        (is_act && rst_s) |=> (row_open && open_bg == $past(cmd_s.bg0) && open_ba == $past(cmd_s.ba)))
        else $error("bank group or bank not latched");
    mr_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (is_mrs && rst_s && mr_sel == 3'(dpis_pkg::MR3)) |=> cfg.gear_quarter == $past(cmd_s.addr[dpis_pkg::MR3_GDM]))
        else $error("mode register write lost");
endmodule // dpis_dev
`default_nettype wire

// File: src/dpis_pkg.sv
// What this block does
// - after power-up or reset, gear-down is half rate and listed modes disabled
// - device initializes its internal state after reset without needing the clock
// - termination stays high-impedance in reset and until clock enable registered high
// - bursts of eight or chopped four; A12 picks chop in on-the-fly mode, A10 auto precharge
// - two bank groups of four banks, one group bit and two bank bits
// - eight words per access, four when chopped, two per clock on both clock edges
package dpis_pkg;

    // sizes
    localparam int MR_NUM  = 7;
    localparam int MR_W    = 14;
    localparam int ROW_W   = 15;
    localparam int ADDR_W  = 18;

    // internal initialization time after reset release
    localparam int CLK_MHZ      = 50;
    localparam int T_INIT_US    = 500;
    localparam int INIT_CYC_DEF = T_INIT_US * CLK_MHZ;

    // burst lengths in beats
    localparam logic [3:0] BEATS_BL8 = 4'h8;
    localparam logic [3:0] BEATS_BC4 = 4'h4;

    // address bit positions
    localparam int A_AP   = 10;
    localparam int A_BC   = 12;
    localparam int A_ZQL  = 10;

    // mode register fields
    localparam int MR0      = 0;
    localparam int MR3      = 3;
    localparam int MR4      = 4;
    localparam int MR5      = 5;
    localparam int MR3_GDM  = 3;
    localparam int MR3_PDA  = 4;
    localparam int MR4_MPS  = 1;
    localparam int MR4_SPPR = 5;
    localparam int MR4_CALL = 6;
    localparam int MR4_HPPR = 13;
    localparam int MR5_PLL  = 0;
    localparam logic [MR_W-1:0] MR_RST = 14'h0000;

    // burst length field of mode register 0
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF  = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;

    // ras_n, cas_n, we_n with act_n high
    localparam logic [2:0] OP_MRS = 3'h0;
    localparam logic [2:0] OP_WR  = 3'h4;
    localparam logic [2:0] OP_RD  = 3'h5;
    localparam logic [2:0] OP_ZQ  = 3'h6;

    // command and address pins
    typedef struct packed {
        logic              cs_n;
        logic              act_n;
        logic [2:0]        op;
        logic              bg0;
        logic [1:0]        ba;
        logic [ADDR_W-1:0] addr;
    } dpis_cmd_t;

    // configuration seen by the rest of the die
    typedef struct packed {
        logic       gear_quarter;
        logic       pda_en;
        logic       mps_en;
        logic [2:0] cs_lat;
        logic [2:0] par_lat;
        logic       hppr_en;
        logic       sppr_en;
    } dpis_cfg_t;

    // device state, gray along the usual path
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_INIT  = 2'b01,
        ST_WCKE  = 2'b11,
        ST_RUN   = 2'b10
    } dpis_state_t;

endpackage

// File: src/dpis_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a bundle of pins
module dpis_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // pins in, synchronised out
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // elaboration check on the width
    if (W < 1) begin : g_bad_w
        $error("dpis_sync: width must be at least one");
    end

    // first stage only feeds the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // dpis_sync
`default_nettype wire

// File: verif/dpis_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller model: reset, command clock, clock enable, termination, commands
module dpis_ctl_model #(
    parameter int INIT_CYC = 8
) (
    // core clock
    input  wire logic           clk,
    // pins to the device
    output logic                reset_pin_n,
    output logic                ck_pin,
    output logic                cke_pin,
    output logic                odt_pin,
    output dpis_pkg::dpis_cmd_t cmd_pin
);
    logic ck_run;

    // pin levels at power-up, termination input held static high
    initial begin
        reset_pin_n = 1'b0;
        cke_pin     = 1'b0;
        odt_pin     = 1'b1;
        cmd_pin     = '1;
        ck_run      = 1'b0;
    end

    // command clock, still until reset is released, phase apart from clk
    initial begin
        ck_pin = 1'b0;
        #7;
        forever #80 ck_pin = ck_run & ~ck_pin;
    end

    // deselect, other lines inverted so nothing stale is seen
    task automatic desel();
        cmd_pin.cs_n  = 1'b1;
        cmd_pin[24:0] = ~cmd_pin[24:0];
    endtask

    // one command held from one falling command clock edge to the next
    task automatic send(input logic act_n, input logic [2:0] op, input logic [2:0] bank,
                        input logic [17:0] a);
        @(negedge ck_pin);
        @(negedge clk);
        cmd_pin = {1'b0, act_n, op, bank, a};
        @(negedge ck_pin);
        @(negedge clk);
        desel();
        repeat (4) @(posedge ck_pin); // command spacing in whole cycles
    endtask

    // reset release, command clock starts
    task automatic start();
        @(negedge clk);
        reset_pin_n = 1'b1;
        ck_run      = 1'b1;
    endtask

    // wait out internal init and a stable clock, then raise clock enable
    task automatic raise_cke();
        repeat (INIT_CYC + 16) @(posedge clk);
        repeat (5) @(posedge ck_pin);
        @(negedge ck_pin);
        @(negedge clk);
        cke_pin = 1'b1;
        repeat (5) @(posedge ck_pin); // reset exit time
    endtask

    // reset pulse in mid-run, clock enable low before release
    task automatic pulse_reset();
        @(negedge clk);
        cke_pin     = 1'b0; // clock enable held low through reset
        reset_pin_n = 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset_pin_n = 1'b1;
    endtask
endmodule // dpis_ctl_model
`default_nettype wire

// File: verif/test_dram_power_up_init_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// bench for the device power-up sequencer
module test_dram_power_up_init_sequencer;
    localparam int INIT_CYC = 8;
    logic                            clk;
    logic                            arst_n;
    logic                            reset_pin_n;
    logic                            ck_pin;
    logic                            cke_pin;
    logic                            odt_pin;
    dpis_pkg::dpis_cmd_t             cmd_pin;
    dpis_pkg::dpis_state_t           state;
    logic                            internal_ready;
    logic                            init_done;
    logic                            odt_term_en;
    dpis_pkg::dpis_cfg_t             cfg;
    logic                            row_open;
    logic                            open_bg;
    logic [1:0]                      open_ba;
    logic [dpis_pkg::ROW_W-1:0]      open_row;
    logic                            burst_active;
    logic                            burst_chop;
    logic                            auto_pre;
    logic                            beat_strobe;
    int                              fail_count;
    int                              n_compared;
    logic [15:0]                     n;

    // device and controller model
    dpis_dev #(.INIT_CYC(INIT_CYC)) i_dpis_dev (
        .clk, .arst_n, .reset_pin_n, .ck_pin, .cke_pin, .odt_pin, .cmd_pin, .state,
        .internal_ready, .init_done, .odt_term_en, .cfg, .row_open, .open_bg, .open_ba,
        .open_row, .burst_active, .burst_chop, .auto_pre, .beat_strobe
    );
    dpis_ctl_model #(.INIT_CYC(INIT_CYC)) i_dpis_ctl_model (
        .clk, .reset_pin_n, .ck_pin, .cke_pin, .odt_pin, .cmd_pin
    );

    // core clock
    always #10 clk = ~clk;

    // comparison and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // bounded wait for a device state
    task automatic wait_state(input dpis_pkg::dpis_state_t s);
        for (int i = 0; i < 64; i++) begin
            if (state === s) return;
            @(negedge clk);
        end
        check(16'(state), 16'(s));
        conclude();
    endtask

    // count beats while a column command goes out
    task automatic column(input logic [2:0] op, input logic [17:0] a);
        n = 16'h0;
        fork
            i_dpis_ctl_model.send(1'b1, op, 3'h6, a);
            repeat (80) begin
                @(negedge clk);
                if (beat_strobe === 1'b1) n++;
            end
        join
    endtask

    // reset defaults and termination off
    task automatic t_reset();
        check(16'(state), 16'(dpis_pkg::ST_RESET));
        check(16'(cfg), 16'h0);
        check(16'(odt_term_en), 16'h0);
        check(16'(internal_ready), 16'h0);
        $display("t_reset done");
    endtask

    // internal init runs on its own, termination waits for clock enable
    task automatic t_power_up();
        i_dpis_ctl_model.start();
        repeat (6) @(negedge clk);
        check(16'(state), 16'(dpis_pkg::ST_INIT));
        check(16'(internal_ready), 16'h0);
        wait_state(dpis_pkg::ST_WCKE);
        check(16'(internal_ready), 16'h1);
        i_dpis_ctl_model.raise_cke();
        check(16'(odt_term_en), 16'h1);
        check(16'(state), 16'(dpis_pkg::ST_RUN));
        check(16'(cfg), 16'h0);
        $display("t_power_up done");
    endtask

    // all mode registers written out of order, fields reach cfg
    task automatic t_mode();
        int          ord[7];
        logic [13:0] mv[7];
        ord = '{3, 6, 5, 4, 2, 1, 0};
        mv  = '{14'h0001, 14'h0000, 14'h0000, 14'h0018, 14'h2162, 14'h0003, 14'h0000};
        foreach (ord[k]) i_dpis_ctl_model.send(1'b1, dpis_pkg::OP_MRS, 3'(ord[k]), {4'h0, mv[ord[k]]});
        check(16'(cfg), 16'h07af);
        $display("t_mode done");
    endtask

    // activate, full burst, chopped write with auto precharge, refused read
    task automatic t_burst();
        i_dpis_ctl_model.send(1'b0, 3'h0, 3'h6, 18'h01234);
        check({open_bg, open_ba, 1'b0, open_row[11:0]}, 16'hc234);
        check(16'(row_open), 16'h1);
        check(16'(open_row), 16'h1234);
        column(dpis_pkg::OP_RD, 18'h01000);
        check(n, 16'h8);
        check({burst_active, burst_chop, auto_pre}, 16'h0);
        column(dpis_pkg::OP_WR, 18'h00400);
        check(n, 16'h4);
        check({row_open, burst_chop, auto_pre}, 16'h3);
        column(dpis_pkg::OP_RD, 18'h01000);
        check(n, 16'h0);
        // fixed chop ignores A12, fixed eight ignores a low A12
        i_dpis_ctl_model.send(1'b1, dpis_pkg::OP_MRS, 3'h0, {16'h0, dpis_pkg::BL_FIX4});
        i_dpis_ctl_model.send(1'b0, 3'h0, 3'h1, 18'h00077);
        check({open_bg, open_ba, 1'b0, open_row[11:0]}, 16'h2077);
        column(dpis_pkg::OP_RD, 18'h01000);
        check(n, 16'h4);
        i_dpis_ctl_model.send(1'b1, dpis_pkg::OP_MRS, 3'h0, {16'h0, dpis_pkg::BL_FIX8});
        column(dpis_pkg::OP_RD, 18'h00000);
        check(n, 16'h8);
        check({row_open, burst_chop, auto_pre}, 16'h4);
        $display("t_burst done");
    endtask

    // long calibration finishes init, then a reset pulse in mid-run
    task automatic t_zq_reset();
        check(16'(init_done), 16'h0);
        i_dpis_ctl_model.send(1'b1, dpis_pkg::OP_ZQ, 3'h0, 18'h00400);
        check(16'(init_done), 16'h1);
        i_dpis_ctl_model.pulse_reset();
        check(16'(state), 16'(dpis_pkg::ST_RESET));
        check({cfg, init_done, odt_term_en}, 16'h0);
        wait_state(dpis_pkg::ST_WCKE);
        i_dpis_ctl_model.raise_cke();
        check(16'(cfg), 16'h0);
        $display("t_zq_reset done");
    endtask

    // main sequence
    initial begin
        clk        = 1'b0;
        arst_n     = 1'b0;
        fail_count = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_power_up();
        t_mode();
        t_burst();
        t_zq_reset();
        conclude();
    end

    // hang guard
    initial begin
        #400000;
        fail_count++;
        conclude();
    end
endmodule // test_dram_power_up_init_sequencer
`default_nettype wire
